// ---- verilog/hsc_holdover_switch_control.sv ----
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ns
// What this block does
// R1 - Track DAC every multiplier times count periods
// R2 - Forced manual policy locks onto named input
// R3 - Lock detect falling edge raises switch event
// R4 - Loss of signal enters holdover when enabled
// R5 - Tune rail reached invalidates input, switches
// R6 - Holdover entry hitless or hard per bit
// R7 - Holdover only while enable bit set
// R8 - Exit holdover after programmed valid cycles
// R9 - Input 0 reference divider, zero reserved
// R10 - Multiplier codes give 4, 64, 1024, 16384
// R11 - Trip code n is (n+1)/64 supply
// R12 - Invalid cycle restarts the exit count
module hsc_holdover_switch_control (
	input wire logic core_clk_i,
	input wire logic arst_n_i,
	input wire logic [hsc_pkg::ADDR_W-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [hsc_pkg::ADDR_W-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic pd_tick_i,
	input wire logic pd_valid_i,
	input wire logic digital_lock_detect_i,
	input wire logic [2:0] loss_of_signal_i,
	input wire logic [hsc_pkg::DAC_W-1:0] dac_value_i,
	input wire logic reference_input_0_i,
	output logic holdover_o,
	output logic [1:0] sel_input_o,
	output logic switch_event_o,
	output logic hitless_switch_o,
	output logic dac_update_o,
	output logic ref0_div_o
);
	import hsc_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [5:0] trip_low;
		logic [5:0] trip_high;
		logic [1:0] mult;
		logic [7:0] upd_cnt;
		logic [7:0] trig;
		logic [13:0] exit_cnt;
		logic [9:0] div;
		logic [1:0] policy;
		hsc_mode_e mode;
		logic [1:0] sel;
		logic [13:0] vcnt;
		logic dld_q;
		logic ref_q;
		logic rail;
		logic sw_ev;
		logic hitless;
		logic pace_ld;
	} hsc_ctl_s;

	hsc_ctl_s st_reg, st_next;

	logic wr_en;
	logic [IDX_W-1:0] wr_idx;
	logic [IDX_W-1:0] rd_idx;
	logic [7:0] wr_byte;
	logic wr_ok;
	logic rd_ok;
	logic [31:0] rd_data;
	logic pre_tick;
	logic upd_tick;
	logic div_tick;
	logic tracking;
	logic [6:0] low_n;
	logic [6:0] high_n;
	logic [10:0] low_thr;
	logic [10:0] high_thr;
	logic rail_now;
	logic dld_fall;
	logic los_cur;
	logic ev;
	logic forced;
	logic ref_rise;
	logic hold_en;
	logic hitless_en;
	logic [1:0] cand1;
	logic [1:0] cand2;
	logic [14:0] vnext;
	logic [9:0] div_load;

	function automatic logic [1:0] next_input(input logic [1:0] x);
		next_input = (x == 2'h2) ? 2'h0 : x + 2'h1;
	endfunction

	function automatic logic mapped(input logic [IDX_W-1:0] idx);
		mapped = ((idx >= IDX_TRIP_LOW) && (idx <= IDX_DIV_LO)) ||
			(idx == IDX_SEL) || (idx == IDX_STAT);
	endfunction

	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------
	hsc_axil u_bus (
		.core_clk_i(core_clk_i),
		.arst_n_i(arst_n_i),
		.awaddr_i(s_axi_awaddr_i),
		.awvalid_i(s_axi_awvalid_i),
		.awready_o(s_axi_awready_o),
		.wdata_i(s_axi_wdata_i),
		.wstrb_i(s_axi_wstrb_i),
		.wvalid_i(s_axi_wvalid_i),
		.wready_o(s_axi_wready_o),
		.bresp_o(s_axi_bresp_o),
		.bvalid_o(s_axi_bvalid_o),
		.bready_i(s_axi_bready_i),
		.araddr_i(s_axi_araddr_i),
		.arvalid_i(s_axi_arvalid_i),
		.arready_o(s_axi_arready_o),
		.rdata_o(s_axi_rdata_o),
		.rresp_o(s_axi_rresp_o),
		.rvalid_o(s_axi_rvalid_o),
		.rready_i(s_axi_rready_i),
		.wr_en_o(wr_en),
		.wr_idx_o(wr_idx),
		.wr_byte_o(wr_byte),
		.wr_ok_i(wr_ok),
		.rd_idx_o(rd_idx),
		.rd_data_i(rd_data),
		.rd_ok_i(rd_ok)
	);

	// Read mux; reserved bits read as zero
	always_comb begin
		rd_ok = mapped(rd_idx);
		wr_ok = mapped(wr_idx);
		rd_data = 32'h0;
		case (rd_idx)
			IDX_TRIP_LOW: rd_data = {26'h0, st_reg.trip_low};
			IDX_MULT_HIGH: rd_data = {24'h0, st_reg.mult, st_reg.trip_high};
			IDX_UPD_CNT: rd_data = {24'h0, st_reg.upd_cnt};
			IDX_TRIG: rd_data = {24'h0, st_reg.trig};
			IDX_EXIT_HI: rd_data = {26'h0, st_reg.exit_cnt[13:8]};
			IDX_EXIT_LO: rd_data = {24'h0, st_reg.exit_cnt[7:0]};
			IDX_DIV_HI: rd_data = {30'h0, st_reg.div[9:8]};
			IDX_DIV_LO: rd_data = {24'h0, st_reg.div[7:0]};
			IDX_SEL: rd_data = {30'h0, st_reg.policy};
			IDX_STAT: rd_data = {28'h0, st_reg.rail, st_reg.sel, holdover_o};
			default: rd_data = 32'h0;
		endcase
	end

	// ----------------------------------------------------------------
	// Trigger detection
	// ----------------------------------------------------------------
	// Trip points in DAC codes: one step of the 6-bit field is 1/64 of full scale
	assign low_n = {1'b0, st_reg.trip_low} + 7'h01;
	assign high_n = {1'b0, st_reg.trip_high} + 7'h01;
	assign low_thr = {low_n, 4'h0}; // R11
	assign high_thr = DAC_FULL - {high_n, 4'h0}; // R11
	assign rail_now = ({1'b0, dac_value_i} <= low_thr) || ({1'b0, dac_value_i} >= high_thr);
	assign dld_fall = st_reg.dld_q & ~digital_lock_detect_i;
	assign los_cur = loss_of_signal_i[st_reg.sel];
	assign hold_en = st_reg.trig[HOLD_EN_BIT];
	assign hitless_en = st_reg.trig[HITLESS_BIT];
	assign forced = (st_reg.policy != POLICY_AUTO) & st_reg.trig[FORCE_BIT];
	assign ev = (st_reg.trig[LOCK_BIT] & dld_fall) | // R3
		(st_reg.trig[LOS_BIT] & los_cur) | // R4
		(st_reg.trig[RAIL_BIT] & rail_now); // R5
	assign cand1 = next_input(st_reg.sel);
	assign cand2 = next_input(cand1);
	assign vnext = {1'b0, st_reg.vcnt} + 15'h0001;
	assign ref_rise = reference_input_0_i & ~st_reg.ref_q;
	assign tracking = (st_reg.mode == ST_TRACK);

	// ----------------------------------------------------------------
	// Control state
	// ----------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		st_next.sw_ev = 1'b0;
		st_next.dld_q = digital_lock_detect_i;
		st_next.ref_q = reference_input_0_i;
		st_next.rail = rail_now;
		// Restart pacing the cycle after a pacing write, when the new value is in force
		st_next.pace_ld = wr_en && ((wr_idx == IDX_UPD_CNT) || (wr_idx == IDX_MULT_HIGH));
		// Register writes; reserved bits are not stored
		if (wr_en) begin
			case (wr_idx)
				IDX_TRIP_LOW: st_next.trip_low = wr_byte[5:0];
				IDX_MULT_HIGH: begin
					st_next.mult = wr_byte[7:MULT_LSB];
					st_next.trip_high = wr_byte[5:0];
				end
				IDX_UPD_CNT: st_next.upd_cnt = wr_byte;
				IDX_TRIG: st_next.trig = wr_byte & 8'h5f;
				IDX_EXIT_HI: st_next.exit_cnt[13:8] = wr_byte[5:0];
				IDX_EXIT_LO: st_next.exit_cnt[7:0] = wr_byte;
				IDX_DIV_HI: st_next.div[9:8] = wr_byte[1:0];
				IDX_DIV_LO: st_next.div[7:0] = wr_byte;
				IDX_SEL: begin
					st_next.policy = wr_byte[1:0];
					if (wr_byte[1:0] != POLICY_AUTO) begin
						st_next.sel = wr_byte[1:0];
					end
				end
				default: st_next.policy = st_reg.policy;
			endcase
		end
		// Decisions use the settings in force this cycle, not the ones being written
		case (st_reg.mode)
			ST_TRACK: begin
				if (ev) begin
					st_next.sw_ev = 1'b1;
					// Move off the bad input unless it is forced
					if (!forced && !loss_of_signal_i[cand1]) begin
						st_next.sel = cand1;
					end else if (!forced && !loss_of_signal_i[cand2]) begin
						st_next.sel = cand2;
					end
					if (hold_en) begin // R7
						st_next.mode = ST_HOLD;
						st_next.hitless = hitless_en; // R6
						st_next.vcnt = 14'h0;
					end else begin
						st_next.hitless = 1'b0;
					end
				end
			end
			ST_HOLD: begin
				if (!hold_en) begin
					st_next.mode = ST_TRACK; // R7
					st_next.vcnt = 14'h0;
				end else if (pd_tick_i) begin
					if (pd_valid_i && !los_cur) begin
						if (vnext >= {1'b0, st_reg.exit_cnt}) begin
							st_next.mode = ST_TRACK; // R8
							st_next.vcnt = 14'h0;
						end else begin
							st_next.vcnt = vnext[13:0]; // R8
						end
					end else begin
						st_next.vcnt = 14'h0; // R12
					end
				end
			end
			default: st_next.mode = ST_TRACK;
		endcase
		// A forced manual input overrides every switch decision
		if (forced) begin
			st_next.sel = st_reg.policy; // R2
		end
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st_reg <= '0;
			st_reg.trip_low <= RST_TRIP_LOW;
			st_reg.trip_high <= RST_TRIP_HIGH;
			st_reg.mult <= RST_MULT;
			st_reg.upd_cnt <= RST_UPD_CNT;
			st_reg.trig <= RST_TRIG;
			st_reg.exit_cnt <= RST_EXIT;
			st_reg.div <= RST_DIV;
			st_reg.policy <= RST_POLICY;
			st_reg.mode <= ST_TRACK;
		end else begin
			st_reg <= st_next;
		end
	end

	// ----------------------------------------------------------------
	// Pacing and division
	// ----------------------------------------------------------------
	// Prescaler runs only while tracking; holdover freezes the DAC anyway
	hsc_cnt #(.W(14)) u_mult (
		.core_clk_i(core_clk_i),
		.arst_n_i(arst_n_i),
		.en_i(pd_tick_i & tracking),
		.clr_i(~tracking | st_reg.pace_ld),
		.load_i(MULT_LOAD[st_reg.mult]), // R10
		.tick_o(pre_tick)
	);

	// A count of zero holds the counter in clear, so no update ever fires
	hsc_cnt #(.W(8)) u_upd (
		.core_clk_i(core_clk_i),
		.arst_n_i(arst_n_i),
		.en_i(pre_tick),
		.clr_i(~tracking | st_reg.pace_ld | (st_reg.upd_cnt == 8'h00)),
		.load_i(st_reg.upd_cnt - 8'h01), // R1
		.tick_o(upd_tick)
	);

	// The reserved divide value of zero behaves as divide by one
	assign div_load = (st_reg.div == 10'h000) ? 10'h000 : st_reg.div - 10'h001;

	hsc_cnt #(.W(10)) u_div (
		.core_clk_i(core_clk_i),
		.arst_n_i(arst_n_i),
		.en_i(ref_rise),
		.clr_i(1'b0),
		.load_i(div_load), // R9
		.tick_o(div_tick)
	);

	assign holdover_o = (st_reg.mode == ST_HOLD);
	assign sel_input_o = st_reg.sel;
	assign switch_event_o = st_reg.sw_ev;
	assign hitless_switch_o = st_reg.hitless;
	assign dac_update_o = upd_tick;
	assign ref0_div_o = div_tick;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!arst_n_i);

	lock_trig_a: assert property (tracking && st_reg.trig[LOCK_BIT] && dld_fall && hold_en // R3
		|=> holdover_o && switch_event_o) else $error("lock loss did not enter holdover");
	los_trig_a: assert property (tracking && st_reg.trig[LOS_BIT] && los_cur && hold_en // R4
		|=> holdover_o) else $error("loss of signal did not enter holdover");
	rail_trig_a: assert property (tracking && st_reg.trig[RAIL_BIT] && rail_now // R5
		|=> switch_event_o) else $error("tune rail did not raise a switch event");
	no_trig_a: assert property (tracking && !ev |=> !switch_event_o && !holdover_o) // R3
		else $error("switch event without an enabled trigger");
	hitless_mode_a: assert property ($rose(holdover_o) |-> hitless_switch_o == $past(hitless_en)) // R6
		else $error("hitless flag does not follow its setting");
	hold_en_a: assert property (!hold_en |=> !holdover_o) // R7
		else $error("holdover while disabled");
	exit_valid_a: assert property ($fell(holdover_o) && $past(hold_en) // R8
		|-> $past(pd_tick_i) && $past(pd_valid_i)) else $error("holdover left without valid tick");
	exit_restart_a: assert property (holdover_o && hold_en && pd_tick_i && !pd_valid_i // R12
		|=> st_reg.vcnt == 14'h0) else $error("exit count not restarted");
	force_sel_a: assert property (forced |=> sel_input_o == $past(st_reg.policy)) // R2
		else $error("forced input not selected");
	upd_off_a: assert property (st_reg.upd_cnt == 8'h00 && $past(st_reg.upd_cnt) == 8'h00 // R1
		|-> !dac_update_o) else $error("DAC update with zero count");
	div_one_a: assert property (st_reg.div == 10'h001 && ref_rise |=> ref0_div_o) // R9
		else $error("divide by one missed an edge");
	trip_low_a: assert property (st_reg.trip_low == 6'h00 && dac_value_i <= 10'h010 // R11
		|-> rail_now) else $error("low trip threshold wrong");

endmodule

// ---- verilog/hsc_pkg.sv ----
package hsc_pkg;

	// ----------------------------------------------------------------
	// Bus geometry
	// ----------------------------------------------------------------
	localparam int ADDR_W = 12;
	localparam int IDX_W = 10;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [IDX_W-1:0] IDX_TRIP_LOW = 10'h14d;
	localparam logic [IDX_W-1:0] IDX_MULT_HIGH = 10'h14e;
	localparam logic [IDX_W-1:0] IDX_UPD_CNT = 10'h14f;
	localparam logic [IDX_W-1:0] IDX_TRIG = 10'h150;
	localparam logic [IDX_W-1:0] IDX_EXIT_HI = 10'h151;
	localparam logic [IDX_W-1:0] IDX_EXIT_LO = 10'h152;
	localparam logic [IDX_W-1:0] IDX_DIV_HI = 10'h153;
	localparam logic [IDX_W-1:0] IDX_DIV_LO = 10'h154;
	localparam logic [IDX_W-1:0] IDX_SEL = 10'h1f0;
	localparam logic [IDX_W-1:0] IDX_STAT = 10'h1f1;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int FORCE_BIT = 6;
	localparam int LOCK_BIT = 4;
	localparam int LOS_BIT = 3;
	localparam int RAIL_BIT = 2;
	localparam int HITLESS_BIT = 1;
	localparam int HOLD_EN_BIT = 0;
	localparam int MULT_LSB = 6;
	localparam int TRIP_SHIFT = 4;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [5:0] RST_TRIP_LOW = 6'h00;
	localparam logic [5:0] RST_TRIP_HIGH = 6'h00;
	localparam logic [1:0] RST_MULT = 2'h0;
	localparam logic [7:0] RST_UPD_CNT = 8'h7f;
	localparam logic [7:0] RST_TRIG = 8'h03;
	localparam logic [13:0] RST_EXIT = 14'h0200;
	localparam logic [9:0] RST_DIV = 10'h078;
	localparam logic [1:0] RST_POLICY = 2'h3;

	// ----------------------------------------------------------------
	// Modes and codes
	// ----------------------------------------------------------------
	localparam logic [1:0] POLICY_AUTO = 2'h3;
	localparam int DAC_W = 10;
	localparam logic [10:0] DAC_FULL = 11'h400;
	localparam logic [13:0] MULT_LOAD [4] = '{14'h0003, 14'h003f, 14'h03ff, 14'h3fff};

	typedef enum logic {ST_TRACK, ST_HOLD} hsc_mode_e;

endpackage

// ---- verilog/hsc_cnt.sv ----
`timescale 1ns/1ns
module hsc_cnt #(
	parameter int W = 8
) (
	input wire logic core_clk_i,
	input wire logic arst_n_i,
	input wire logic en_i,
	input wire logic clr_i,
	input wire logic [W-1:0] load_i,
	output logic tick_o
);
	import hsc_pkg::*;

	typedef struct packed {
		logic [W-1:0] cnt;
		logic tick;
	} hsc_cnt_s;

	hsc_cnt_s st_reg, st_next;

	// Reload counter: one tick every load_i+1 enables; clear wins.
	// A count left above a lowered reload value ends its period at once,
	// so a smaller setting never waits out the old, longer one.
	always_comb begin
		st_next = st_reg;
		st_next.tick = 1'b0;
		if (clr_i) begin
			st_next.cnt = load_i;
		end else if (en_i) begin
			if ((st_reg.cnt == '0) || (st_reg.cnt > load_i)) begin
				st_next.cnt = load_i;
				st_next.tick = 1'b1;
			end else begin
				st_next.cnt = st_reg.cnt - 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign tick_o = st_reg.tick;

endmodule

// ---- verilog/hsc_axil.sv ----
`timescale 1ns/1ns
module hsc_axil (
	input wire logic core_clk_i,
	input wire logic arst_n_i,
	input wire logic [hsc_pkg::ADDR_W-1:0] awaddr_i,
	input wire logic awvalid_i,
	output logic awready_o,
	input wire logic [31:0] wdata_i,
	input wire logic [3:0] wstrb_i,
	input wire logic wvalid_i,
	output logic wready_o,
	output logic [1:0] bresp_o,
	output logic bvalid_o,
	input wire logic bready_i,
	input wire logic [hsc_pkg::ADDR_W-1:0] araddr_i,
	input wire logic arvalid_i,
	output logic arready_o,
	output logic [31:0] rdata_o,
	output logic [1:0] rresp_o,
	output logic rvalid_o,
	input wire logic rready_i,
	output logic wr_en_o,
	output logic [hsc_pkg::IDX_W-1:0] wr_idx_o,
	output logic [7:0] wr_byte_o,
	input wire logic wr_ok_i,
	output logic [hsc_pkg::IDX_W-1:0] rd_idx_o,
	input wire logic [31:0] rd_data_i,
	input wire logic rd_ok_i
);
	import hsc_pkg::*;

	typedef struct packed {
		logic aw_full;
		logic [IDX_W-1:0] aw_idx;
		logic w_full;
		logic [7:0] w_byte;
		logic w_lane0;
		logic awrdy;
		logic wrdy;
		logic bvalid;
		logic [1:0] bresp;
		logic arrdy;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} hsc_axil_s;

	hsc_axil_s st_reg, st_next;
	logic do_wr;

	// Address and data are caught independently, the write fires once both are held
	always_comb begin
		st_next = st_reg;
		do_wr = st_reg.aw_full & st_reg.w_full & ~st_reg.bvalid;
		if (awvalid_i && st_reg.awrdy) begin
			st_next.aw_full = 1'b1;
			st_next.aw_idx = awaddr_i[ADDR_W-1:2];
		end
		if (wvalid_i && st_reg.wrdy) begin
			st_next.w_full = 1'b1;
			st_next.w_byte = wdata_i[7:0];
			st_next.w_lane0 = wstrb_i[0];
		end
		if (do_wr) begin
			st_next.aw_full = 1'b0;
			st_next.w_full = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bresp = wr_ok_i ? RESP_OKAY : RESP_SLVERR;
		end
		if (st_reg.bvalid && bready_i) begin
			st_next.bvalid = 1'b0;
		end
		if (arvalid_i && st_reg.arrdy) begin
			st_next.rvalid = 1'b1;
			st_next.rdata = rd_data_i;
			st_next.rresp = rd_ok_i ? RESP_OKAY : RESP_SLVERR;
		end
		if (st_reg.rvalid && rready_i) begin
			st_next.rvalid = 1'b0;
		end
		// Readies are registered so that every bus output leaves a flop
		st_next.awrdy = ~st_next.aw_full & ~st_next.bvalid;
		st_next.wrdy = ~st_next.w_full & ~st_next.bvalid;
		st_next.arrdy = ~st_next.rvalid;
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign awready_o = st_reg.awrdy;
	assign wready_o = st_reg.wrdy;
	assign bvalid_o = st_reg.bvalid;
	assign bresp_o = st_reg.bresp;
	assign arready_o = st_reg.arrdy;
	assign rvalid_o = st_reg.rvalid;
	assign rdata_o = st_reg.rdata;
	assign rresp_o = st_reg.rresp;
	// Only byte lane 0 carries register bits
	assign wr_en_o = do_wr & st_reg.w_lane0;
	assign wr_idx_o = st_reg.aw_idx;
	assign wr_byte_o = st_reg.w_byte;
	assign rd_idx_o = araddr_i[ADDR_W-1:2];

endmodule

// ---- testbench/hsc_ref_model.sv ----
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Far side: reference inputs and first loop status
// ----------------------------------------------------------------
module hsc_ref_model (
	input wire logic core_clk_i,
	input wire logic tick_i,
	input wire logic valid_i,
	input wire logic lock_i,
	input wire logic [2:0] los_i,
	input wire logic [9:0] dac_i,
	input wire logic ref_en_i,
	output logic pd_tick_o,
	output logic pd_valid_o,
	output logic dld_o,
	output logic [2:0] los_o,
	output logic [9:0] dac_o,
	output logic ref0_o
);
	// Valid only means something with the tick; between ticks it shows the opposite level,
	// so sampling it at the wrong moment gives the wrong answer
	always @(posedge core_clk_i) begin
		pd_tick_o <= tick_i;
		pd_valid_o <= tick_i ? valid_i : ~valid_i;
		dld_o <= lock_i;
		los_o <= los_i;
		dac_o <= dac_i;
		ref0_o <= ref_en_i ? ~ref0_o : 1'b0; // Reference stands low when stopped
	end
endmodule

// ---- testbench/hsc_holdover_switch_control_tb.sv ----
`timescale 1ns/1ns
module hsc_holdover_switch_control_tb;
	import hsc_pkg::*;
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = '0, rdata;
	logic [3:0] wstrb = '0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, sel;
	logic tick_r = 1'b0, valid_r = 1'b0, lock_r = 1'b1, ref_en = 1'b0;
	logic [2:0] los_r = '0, loss_of_signal;
	logic [9:0] dac_r = 10'h200, dac;
	logic pd_tick, pd_valid, digital_lock_detect, ref0, hold, sw_ev, hitless, dac_upd, div_p;
	int error_cnt = 0, checked = 0, ev_cnt = 0, upd_cnt = 0, div_cnt = 0, ev0 = 0, u0;
	logic [9:0] ri [6] = '{IDX_UPD_CNT, IDX_TRIG, IDX_EXIT_HI, IDX_EXIT_LO, IDX_DIV_HI, IDX_DIV_LO};
	logic [7:0] rv [6] = '{8'h7f, 8'h03, 8'h02, 8'h00, 8'h00, 8'h78};

	hsc_holdover_switch_control i_hsc_holdover_switch_control (
		.core_clk_i(core_clk), .arst_n_i(arst_n),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .pd_tick_i(pd_tick),
		.pd_valid_i(pd_valid), .digital_lock_detect_i(digital_lock_detect), .loss_of_signal_i(loss_of_signal),
		.dac_value_i(dac), .reference_input_0_i(ref0), .holdover_o(hold), .sel_input_o(sel),
		.switch_event_o(sw_ev), .hitless_switch_o(hitless), .dac_update_o(dac_upd),
		.ref0_div_o(div_p));

	hsc_ref_model i_hsc_ref_model (.core_clk_i(core_clk), .tick_i(tick_r), .valid_i(valid_r),
		.lock_i(lock_r), .los_i(los_r), .dac_i(dac_r), .ref_en_i(ref_en), .pd_tick_o(pd_tick),
		.pd_valid_o(pd_valid), .dld_o(digital_lock_detect), .los_o(loss_of_signal), .dac_o(dac), .ref0_o(ref0));

	// ----------------------------------------------------------------
	// Clock and pulse counters
	// ----------------------------------------------------------------
	initial begin
		forever #20 core_clk = ~core_clk;
	end

	// Pulses are counted mid-cycle, away from the edge that changes them
	always @(negedge core_clk) begin
		if (sw_ev === 1'b1) ev_cnt++;
		if (dac_upd === 1'b1) upd_cnt++;
		if (div_p === 1'b1) div_cnt++;
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Handshakes are judged at the negedge before the edge that completes them
	task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er);
		logic ta, tw, tb, done;
		logic [1:0] r;
		done = 1'b0;
		@(posedge core_clk);
		awaddr <= {idx, 2'h0};
		wdata <= {24'h0, d};
		wstrb <= 4'h1;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!done) begin
			@(negedge core_clk);
			ta = awvalid & awready;
			tw = wvalid & wready;
			tb = bvalid;
			r = bresp;
			@(posedge core_clk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tb) bready <= 1'b0;
			done = tb;
		end
		cmp({30'h0, r}, {30'h0, er});
	endtask

	task automatic rd(input logic [9:0] idx, input logic [31:0] ed, input logic [1:0] er);
		logic ta, done;
		logic [31:0] d;
		logic [1:0] r;
		done = 1'b0;
		@(posedge core_clk);
		araddr <= {idx, 2'h0};
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!done) begin
			@(negedge core_clk);
			ta = arvalid & arready;
			done = rvalid;
			d = rdata;
			r = rresp;
			@(posedge core_clk);
			if (ta) arvalid <= 1'b0;
			if (done) rready <= 1'b0;
		end
		cmp(d, ed);
		cmp({30'h0, r}, {30'h0, er});
	endtask

	task automatic pd(input logic v, input int n);
		repeat (n) begin
			@(posedge core_clk);
			tick_r <= 1'b1;
			valid_r <= v;
			@(posedge core_clk);
			tick_r <= 1'b0;
			repeat (2) @(posedge core_clk);
		end
	endtask

	task automatic lk();
		@(posedge core_clk);
		lock_r <= 1'b0;
		repeat (3) @(posedge core_clk);
		lock_r <= 1'b1;
		repeat (4) @(posedge core_clk);
	endtask

	// Negative count means at least one event
	task automatic ev_chk(input int e);
		if (e < 0) cmp(32'(ev_cnt > ev0), 32'h1);
		else cmp(ev_cnt - ev0, e);
		ev0 = ev_cnt;
	endtask

	task automatic st(input logic h, input logic [1:0] s, input logic hl);
		@(negedge core_clk);
		cmp({28'h0, hold, sel, hitless}, {28'h0, h, s, hl});
	endtask

	task automatic rail(input logic [9:0] v, input int e);
		@(posedge core_clk);
		dac_r <= v;
		repeat (3) @(posedge core_clk);
		dac_r <= 10'h200;
		repeat (4) @(posedge core_clk);
		ev_chk(e);
	endtask

	task automatic stop_test;
		$display("mismatches %0d comparisons %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Whole run needs under a thousand cycles
	initial begin
		repeat (20000) @(posedge core_clk);
		error_cnt++;
		stop_test;
	end

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		repeat (10) @(posedge core_clk);
		arst_n <= 1'b1;
		foreach (ri[i]) rd(ri[i], {24'h0, rv[i]}, RESP_OKAY);
		rd(10'h100, 32'h0, RESP_SLVERR);
		wr(10'h100, 8'h55, RESP_SLVERR);
		wr(IDX_TRIG, 8'hff, RESP_OKAY);
		rd(IDX_TRIG, 32'h5f, RESP_OKAY);
		wr(IDX_TRIG, 8'h13, RESP_OKAY);
		lk();
		ev_chk(1);
		st(1'b1, 2'h1, 1'b1);
		wr(IDX_EXIT_LO, 8'h03, RESP_OKAY);
		wr(IDX_EXIT_HI, 8'h00, RESP_OKAY);
		pd(1'b1, 2);
		pd(1'b0, 1);
		pd(1'b1, 2);
		st(1'b1, 2'h1, 1'b1);
		pd(1'b1, 1);
		st(1'b0, 2'h1, 1'b1);
		wr(IDX_TRIG, 8'h09, RESP_OKAY);
		@(posedge core_clk);
		los_r <= 3'b010;
		repeat (4) @(posedge core_clk);
		los_r <= 3'b000;
		ev_chk(1);
		st(1'b1, 2'h2, 1'b0);
		wr(IDX_TRIG, 8'h08, RESP_OKAY);
		st(1'b0, 2'h2, 1'b0);
		@(posedge core_clk);
		los_r <= 3'b100;
		repeat (4) @(posedge core_clk);
		los_r <= 3'b000;
		ev_chk(1);
		st(1'b0, 2'h0, 1'b0);
		wr(IDX_TRIG, 8'h01, RESP_OKAY);
		lk();
		ev_chk(0);
		wr(IDX_SEL, 8'h01, RESP_OKAY);
		wr(IDX_TRIG, 8'h52, RESP_OKAY);
		lk();
		st(1'b0, 2'h1, 1'b0);
		wr(IDX_TRIG, 8'h04, RESP_OKAY);
		ev0 = ev_cnt;
		rail(10'h3ff, -1);
		rail(10'h010, -1);
		rail(10'h011, 0);
		rail(10'h3ef, 0);
		rail(10'h3f0, -1);
		wr(IDX_TRIG, 8'h00, RESP_OKAY);
		wr(IDX_MULT_HIGH, 8'h00, RESP_OKAY);
		wr(IDX_UPD_CNT, 8'h02, RESP_OKAY);
		u0 = upd_cnt;
		pd(1'b1, 7);
		cmp(upd_cnt - u0, 0);
		pd(1'b1, 1);
		repeat (4) @(posedge core_clk);
		cmp(upd_cnt - u0, 1);
		wr(IDX_MULT_HIGH, 8'h40, RESP_OKAY);
		wr(IDX_UPD_CNT, 8'h01, RESP_OKAY);
		u0 = upd_cnt;
		pd(1'b1, 63);
		cmp(upd_cnt - u0, 0);
		pd(1'b1, 1);
		repeat (4) @(posedge core_clk);
		cmp(upd_cnt - u0, 1);
		wr(IDX_UPD_CNT, 8'h00, RESP_OKAY);
		u0 = upd_cnt;
		pd(1'b1, 70);
		cmp(upd_cnt - u0, 0);
		wr(IDX_DIV_LO, 8'h03, RESP_OKAY);
		u0 = div_cnt;
		@(posedge core_clk);
		ref_en <= 1'b1;
		repeat (24) @(posedge core_clk);
		ref_en <= 1'b0;
		repeat (4) @(posedge core_clk);
		cmp(div_cnt - u0, 4);
		wr(IDX_DIV_LO, 8'h01, RESP_OKAY);
		u0 = div_cnt;
		@(posedge core_clk);
		ref_en <= 1'b1;
		repeat (8) @(posedge core_clk);
		ref_en <= 1'b0;
		repeat (4) @(posedge core_clk);
		cmp(div_cnt - u0, 4);
		stop_test;
	end
endmodule
